// ===== dqel_queue_status.sv
// Event latch, two event queues, queue status and activity status
`timescale 1ns/1ps
`include "dqel_params.svh"

// Functional notes
// - Count at or above a queue's limit sets its over-limit and error flags.
// - Limit fields hold 0..16, reset to 16; 17 disables; 18+ forbidden.
// - Queue 1 limit in bits 12:8, queue 0 limit in bits 4:0.
// - Peak field 20:16 holds largest count since reset or last clear.
// - Error-clear write of 1 resets that queue's peak to the current count and clears its over-limit bit.
// - Status bits 12:8 show the instantaneous entry count, 0 to 16.
// - Status bits 3:0 show the head entry index, 0 to 15.
// - Activity bits 17 and 16 show queue 1 and queue 0 non-empty.
// - Completion counter 13:8 increments on submissions asking completion.
// - Completion counter decrements on every returned completion code, except at 0 with no increment in the same cycle.
// - At count 63 no new transfer request is submitted.
// - Busy bit 4 is the OR of all activity bits during a request's life.
// - Bit 3 shows write status request active or responses pending.
// - Bit 2 shows request processing and submission logic active.
// - Bit 1 shows an enabled quick event pending.
// - Bit 0 shows an enabled latched, manual or chained event pending.
// - Every external event is latched, enabled or not.
// - Only enabled latched events are prioritised and queued.
// - A latch bit clears when its event is prioritised and serviced.
// - New event on a set, enabled latch bit sets its missed flag.
// - Writing 1 to event-clear clears the latch bit.
// - Set beats clear in the same cycle; a lost event on an enabled bit marks missed.
// - Error-clear write of 1 also clears the queue error flag; 0 no effect.
// - Shadow view: ungranted bits read 0 and ignore writes.
module dqel_queue_status
  import dqel_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] eventIn,
  input wire logic [31:0] chanQueueSel,
  input wire logic [31:0] completionIrqEn,
  input wire logic [31:0] completionChainEn,
  input wire logic [31:0] manualEventSet,
  input wire logic [31:0] chainTriggerFlags,
  input wire logic [7:0] quickTriggerFlags,
  input wire logic [7:0] quickEnable,
  input wire logic writeStatusReq,
  input wire logic writeStatusFifoPending,
  output logic xferReqValid,
  input wire logic xferReqReady,
  output logic xferReqQueue,
  output logic [4:0] xferReqChannel,
  output logic xferReqCompletion,
  input wire logic completionValid,
  output logic [1:0] queueOverLimitError
);

  dqel_state_type regs_ff;
  dqel_state_type nxt_regs;

  // ****************************************
  // Bus decode
  // ****************************************
  logic apbSetup;
  logic apbWrite;
  logic [31:0] evClrBits;
  logic [31:0] missClrBits;
  logic [1:0] errClr;

  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = regs_ff.rdata;

  always_comb begin
    evClrBits = 32'h0;
    missClrBits = 32'h0;
    errClr = 2'h0;
    if (apbWrite) begin
      unique case (paddr)
        `DQEL_OFS_EVCLEAR: evClrBits = pwdata;
        `DQEL_OFS_SH_EVCLEAR: evClrBits = pwdata & regs_ff.grant;
        `DQEL_OFS_MISSED: missClrBits = pwdata;
        `DQEL_OFS_SH_MISSED: missClrBits = pwdata & regs_ff.grant;
        `DQEL_OFS_ERRCLEAR: errClr = pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Event prioritiser
  // ****************************************
  logic [1:0] queueFull;
  logic [31:0] candidate;
  logic enqValid;
  logic [4:0] pickChan;
  logic enqQueue;
  logic [31:0] serviced;

  assign queueFull[0] = regs_ff.count[0] == `DQEL_QUEUE_FULL;
  assign queueFull[1] = regs_ff.count[1] == `DQEL_QUEUE_FULL;

  // A full queue only blocks its own channels, not the other queue's
  genvar ch;
  generate
    for (ch = 0; ch < 32; ch++) begin : g_cand
      assign candidate[ch] = regs_ff.latch[ch] & regs_ff.mask[ch] &
        ~queueFull[chanQueueSel[ch]];
    end
  endgenerate

  always_comb begin
    pickChan = 5'h0;
    for (int i = 31; i >= 0; i--) begin
      if (candidate[i]) begin
        pickChan = 5'(i);
      end
    end
  end

  assign enqValid = |candidate;
  assign enqQueue = chanQueueSel[pickChan];
  assign serviced = enqValid ? (32'h1 << pickChan) : 32'h0;

  // ****************************************
  // Submission to the transfer controllers
  // ****************************************
  logic [1:0] nonEmpty;
  logic stall;
  logic fire;
  logic compInc;
  logic compDec;
  logic requestBusy;
  logic writeBusy;
  logic quickBusy;
  logic eventBusy;
  logic ctrlBusy;

  assign nonEmpty[0] = regs_ff.count[0] != 5'h0;
  assign nonEmpty[1] = regs_ff.count[1] != 5'h0;
  // Fixed priority: queue 0 ahead of queue 1, one request per cycle
  assign stall = regs_ff.compCount == `DQEL_COMP_MAX;
  assign xferReqValid = (|nonEmpty) & ~stall;
  assign xferReqQueue = ~nonEmpty[0];
  assign xferReqChannel =
    regs_ff.entries[xferReqQueue][regs_ff.head[xferReqQueue]];
  assign xferReqCompletion = completionIrqEn[xferReqChannel] |
    completionChainEn[xferReqChannel];
  assign fire = xferReqValid & xferReqReady;
  assign compInc = fire & xferReqCompletion;
  assign compDec = completionValid &
    ((regs_ff.compCount != 6'h0) | compInc);

  assign requestBusy = xferReqValid;
  assign writeBusy = writeStatusReq | writeStatusFifoPending;
  assign quickBusy = |(quickTriggerFlags & quickEnable);
  assign eventBusy = (|(regs_ff.latch & regs_ff.mask)) |
    (|manualEventSet) | (|chainTriggerFlags);
  assign ctrlBusy = requestBusy | writeBusy | quickBusy | eventBusy |
    (|nonEmpty) | (regs_ff.compCount != 6'h0);

  assign queueOverLimitError = regs_ff.err;

  // ****************************************
  // Next state
  // ****************************************
  logic [31:0] rdMux;

  always_comb begin
    rdMux = 32'h0;
    unique case (paddr)
      `DQEL_OFS_QFILL0, `DQEL_OFS_QFILL1: begin
        rdMux = {7'h0, regs_ff.over[paddr[2]], 3'h0,
          regs_ff.peak[paddr[2]], 3'h0, regs_ff.count[paddr[2]],
          4'h0, regs_ff.head[paddr[2]]};
      end
      `DQEL_OFS_LIMIT: begin
        rdMux = {19'h0, regs_ff.limit[1], 3'h0, regs_ff.limit[0]};
      end
      `DQEL_OFS_ACTIVITY: begin
        rdMux = {14'h0, nonEmpty, 2'h0, regs_ff.compCount, 3'h0,
          ctrlBusy, writeBusy, requestBusy, quickBusy, eventBusy};
      end
      `DQEL_OFS_LATCH: rdMux = regs_ff.latch;
      `DQEL_OFS_ENABLE: rdMux = regs_ff.mask;
      `DQEL_OFS_MISSED: rdMux = regs_ff.missed;
      `DQEL_OFS_ERRFLAGS: rdMux = {30'h0, regs_ff.err};
      `DQEL_OFS_GRANT: rdMux = regs_ff.grant;
      `DQEL_OFS_SH_LATCH: rdMux = regs_ff.latch & regs_ff.grant;
      `DQEL_OFS_SH_ENABLE: rdMux = regs_ff.mask & regs_ff.grant;
      `DQEL_OFS_SH_MISSED: rdMux = regs_ff.missed & regs_ff.grant;
      default: rdMux = 32'h0;
    endcase
  end

  always_comb begin
    logic inc;
    logic dec;
    logic hit;
    logic [3:0] tail;
    logic [4:0] peakBase;
    inc = 1'b0;
    dec = 1'b0;
    hit = 1'b0;
    tail = 4'h0;
    peakBase = 5'h0;
    nxt_regs = regs_ff;

    // Read data is fetched in the setup cycle so the access has no wait
    if (apbSetup && !pwrite) begin
      nxt_regs.rdata = rdMux;
    end

    if (apbWrite) begin
      unique case (paddr)
        `DQEL_OFS_LIMIT: begin
          nxt_regs.limit[1] = pwdata[`DQEL_LIM1_MSB:`DQEL_LIM1_LSB];
          nxt_regs.limit[0] = pwdata[`DQEL_LIM0_MSB:`DQEL_LIM0_LSB];
        end
        `DQEL_OFS_ENABLE: nxt_regs.mask = pwdata;
        `DQEL_OFS_SH_ENABLE: begin
          nxt_regs.mask = (regs_ff.mask & ~regs_ff.grant) |
            (pwdata & regs_ff.grant);
        end
        `DQEL_OFS_GRANT: nxt_regs.grant = pwdata;
        default: begin
        end
      endcase
    end

    // Set beats any clear; a lost event on an enabled bit is remembered as missed
    nxt_regs.latch = eventIn |
      (regs_ff.latch & ~(serviced | evClrBits));
    nxt_regs.missed = (eventIn & regs_ff.latch & regs_ff.mask) |
      (regs_ff.missed & ~missClrBits);

    for (int q = 0; q < 2; q++) begin
      inc = enqValid && (enqQueue == q[0]);
      dec = fire && (xferReqQueue == q[0]);
      tail = regs_ff.head[q] + regs_ff.count[q][3:0];
      if (inc) begin
        nxt_regs.entries[q][tail] = pickChan;
      end
      nxt_regs.count[q] = regs_ff.count[q] + {4'h0, inc} -
        {4'h0, dec};
      nxt_regs.head[q] = regs_ff.head[q] + {3'h0, dec};

      // Limit 17 never matches because the compare with DQEL_LIMIT_OFF gates the hit
      hit = (regs_ff.limit[q] != `DQEL_LIMIT_OFF) &&
        (regs_ff.count[q] >= regs_ff.limit[q]);
      nxt_regs.over[q] = hit | (regs_ff.over[q] & ~errClr[q]);
      nxt_regs.err[q] = hit | (regs_ff.err[q] & ~errClr[q]);
      peakBase = errClr[q] ? 5'h0 : regs_ff.peak[q];
      nxt_regs.peak[q] = (regs_ff.count[q] > peakBase) ?
        regs_ff.count[q] : peakBase;
    end

    nxt_regs.compCount = regs_ff.compCount + {5'h0, compInc} -
      {5'h0, compDec};
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regs_ff <= '0;
      regs_ff.limit[0] <= `DQEL_LIMIT_RESET;
      regs_ff.limit[1] <= `DQEL_LIMIT_RESET;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_stall_block: assert property (
    regs_ff.compCount == 6'h3f |-> !xferReqValid)
    else $error("request offered with 63 completions outstanding");

  a_comp_count: assert property (
    compInc && !completionValid |=>
      regs_ff.compCount == $past(regs_ff.compCount) + 6'h1)
    else $error("completion counter did not increment");

  a_comp_return: assert property (
    completionValid && !compInc && regs_ff.compCount != 6'h0 |=>
      regs_ff.compCount == $past(regs_ff.compCount) - 6'h1)
    else $error("completion counter did not decrement");

  a_latch_capture: assert property (
    eventIn != 32'h0 |=> (regs_ff.latch & $past(eventIn)) == $past(eventIn))
    else $error("external event not latched");

  a_missed_mark: assert property (
    (eventIn & regs_ff.latch & regs_ff.mask) != 32'h0 |=>
      (regs_ff.missed & $past(eventIn & regs_ff.latch & regs_ff.mask)) ==
      $past(eventIn & regs_ff.latch & regs_ff.mask))
    else $error("missed event not recorded");

  a_clear_latch: assert property (
    (evClrBits & ~eventIn) != 32'h0 |=>
      (regs_ff.latch & $past(evClrBits & ~eventIn)) == 32'h0)
    else $error("event clear did not clear latch");

  a_disabled_hold: assert property (
    enqValid |-> regs_ff.mask[pickChan] && regs_ff.latch[pickChan])
    else $error("disabled event was queued");

  a_service_clear: assert property (
    enqValid && !eventIn[pickChan] |=> !regs_ff.latch[$past(pickChan)])
    else $error("serviced event still latched");

  a_set_wins: assert property (
    (eventIn & evClrBits) != 32'h0 |=>
      (regs_ff.latch & $past(eventIn & evClrBits)) ==
      $past(eventIn & evClrBits))
    else $error("clear beat a new event");

  genvar gq;
  generate
    for (gq = 0; gq < 2; gq++) begin : g_chk
      a_limit_hit: assert property (
        regs_ff.limit[gq] <= 5'h10 &&
        regs_ff.count[gq] >= regs_ff.limit[gq] |=>
          regs_ff.over[gq] && regs_ff.err[gq])
        else $error("over-limit not flagged");

      a_limit_off: assert property (
        regs_ff.limit[gq] == 5'h11 && !regs_ff.over[gq] |=>
          !regs_ff.over[gq])
        else $error("disabled limit raised over-limit");

      a_peak_follow: assert property (
        regs_ff.count[gq] > regs_ff.peak[gq] |=>
          regs_ff.peak[gq] == $past(regs_ff.count[gq]))
        else $error("peak did not follow count");

      a_errclr_peak: assert property (
        errClr[gq] && regs_ff.count[gq] == 5'h0 |=>
          regs_ff.peak[gq] == 5'h0)
        else $error("error clear did not reset peak");

      a_head_wrap: assert property (
        fire && xferReqQueue == gq[0] |=>
          regs_ff.head[gq] == $past(regs_ff.head[gq]) + 4'h1)
        else $error("head index did not advance");

      a_count_range: assert property (
        regs_ff.count[gq] <= 5'h10)
        else $error("entry count above 16");
    end
  endgenerate

  c_submit: cover property (fire ##1 completionValid);
  c_missed: cover property ((eventIn & regs_ff.latch & regs_ff.mask) != 0);
  c_stall: cover property (regs_ff.compCount == 6'h3f);
  c_full: cover property (regs_ff.count[0] == 5'h10);
  c_errclr: cover property (errClr != 2'h0 && regs_ff.over != 2'h0);

endmodule

// ===== dqel_params.svh
// Constants for the queue status and event latch block
`ifndef DQEL_PARAMS_SVH
`define DQEL_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define DQEL_OFS_QFILL0 8'h00
`define DQEL_OFS_QFILL1 8'h04
`define DQEL_OFS_LIMIT 8'h08
`define DQEL_OFS_ACTIVITY 8'h0c
`define DQEL_OFS_LATCH 8'h10
`define DQEL_OFS_ENABLE 8'h14
`define DQEL_OFS_EVCLEAR 8'h18
`define DQEL_OFS_MISSED 8'h1c
`define DQEL_OFS_ERRFLAGS 8'h20
`define DQEL_OFS_ERRCLEAR 8'h24
`define DQEL_OFS_GRANT 8'h28
`define DQEL_OFS_SH_LATCH 8'h40
`define DQEL_OFS_SH_ENABLE 8'h44
`define DQEL_OFS_SH_EVCLEAR 8'h48
`define DQEL_OFS_SH_MISSED 8'h4c

// ****************************************
// Field positions
// ****************************************
`define DQEL_LIM1_MSB 12
`define DQEL_LIM1_LSB 8
`define DQEL_LIM0_MSB 4
`define DQEL_LIM0_LSB 0

// ****************************************
// Values and limits
// ****************************************
`define DQEL_LIMIT_RESET 5'h10
`define DQEL_LIMIT_OFF 5'h11
`define DQEL_QUEUE_FULL 5'h10
`define DQEL_COMP_MAX 6'h3f

`endif

// ===== dqel_pkg.sv
// Types shared by the queue status and event latch block
package dqel_pkg;

  typedef struct packed {
    logic [31:0] latch;
    logic [31:0] mask;
    logic [31:0] missed;
    logic [31:0] grant;
    logic [1:0][4:0] limit;
    logic [1:0][4:0] count;
    logic [1:0][3:0] head;
    logic [1:0][4:0] peak;
    logic [1:0] over;
    logic [1:0] err;
    logic [1:0][15:0][4:0] entries;
    logic [5:0] compCount;
    logic [31:0] rdata;
  } dqel_state_type;

endpackage

// ===== dqel_far_end.sv
// Far-end model: transfer controller taking requests, returning codes
`timescale 1ns/1ps
// ******************
// Transfer controller
// ******************
module dqel_far_end (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic holdComp,
  input wire logic xferReqValid,
  input wire logic xferReqCompletion,
  output logic xferReqReady,
  output logic completionValid
);
  int pend;
  logic issue;
  logic take;
  assign take = xferReqValid && xferReqReady && xferReqCompletion;
  // One code per pulse, never two pulses back to back
  assign issue = !holdComp && pend > 0 && !completionValid;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 0;
      xferReqReady <= 1'b0;
      completionValid <= 1'b0;
    end else begin
      // Random acceptance so both prompt and slow answers occur
      xferReqReady <= !stall && 1'($urandom);
      completionValid <= issue;
      pend <= pend + int'(take) - int'(issue);
    end
  end
endmodule

// ===== dqel_queue_status_bench.sv
// Self-checking bench for the queue status and event latch block
`timescale 1ns/1ps
`include "dqel_params.svh"
module dqel_queue_status_bench;
  logic clock = 0, rst_n, psel, penable, pwrite, pready, pslverr;
  logic xferReqValid, xferReqReady, xferReqQueue, xferReqCompletion;
  logic completionValid, writeStatusReq, stall, holdComp, wb, qb, eb;
  logic writeStatusFifoPending;
  logic [31:0] manualEventSet, chainTriggerFlags, completionChainEn;
  logic [7:0] paddr, sa, quickTriggerFlags, quickEnable;
  logic [31:0] pwdata, prdata, eventIn, chanQueueSel, completionIrqEn, rd;
  logic [4:0] xferReqChannel, ch;
  logic [1:0] queueOverLimitError;
  int errors = 0, cmp_count = 0, pops = 0, q, k;
  always #10 clock = ~clock;
  dqel_queue_status dqel_queue_status_i (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eventIn(eventIn), .chanQueueSel(chanQueueSel),
    .completionIrqEn(completionIrqEn),
    .completionChainEn(completionChainEn),
    .manualEventSet(manualEventSet), .chainTriggerFlags(chainTriggerFlags),
    .quickTriggerFlags(quickTriggerFlags), .quickEnable(quickEnable),
    .writeStatusReq(writeStatusReq),
    .writeStatusFifoPending(writeStatusFifoPending),
    .xferReqValid(xferReqValid), .xferReqReady(xferReqReady),
    .xferReqQueue(xferReqQueue), .xferReqChannel(xferReqChannel),
    .xferReqCompletion(xferReqCompletion),
    .completionValid(completionValid),
    .queueOverLimitError(queueOverLimitError));
  dqel_far_end dqel_far_end_i (.clock(clock), .rst_n(rst_n),
    .stall(stall), .holdComp(holdComp), .xferReqValid(xferReqValid),
    .xferReqCompletion(xferReqCompletion), .xferReqReady(xferReqReady),
    .completionValid(completionValid));
  // ******************
  // Helpers
  // ******************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    chk({31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic ev;
    @(posedge clock);
    eventIn <= 32'h1 << ch;
    @(posedge clock);
    eventIn <= 32'h0;
    repeat (2) @(posedge clock);
  endtask
  // Bounded, so a stuck queue ends in a mismatch, not a hang
  task automatic waitPops(input int n);
    for (k = 0; k < 600 && pops < n; k++) @(posedge clock);
    chk(pops, n);
  endtask
  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask
  function automatic logic [31:0] st(input logic o, input logic [4:0] p,
                                     input logic [4:0] c,
                                     input logic [3:0] h);
    return {7'h0, o, 3'h0, p, 3'h0, c, 4'h0, h};
  endfunction
  task final_report;
    $display("Compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock) begin
    if (rst_n && xferReqValid && xferReqReady) begin
      pops++;
      chk({27'h0, xferReqChannel}, {27'h0, ch});
      chk({31'h0, xferReqQueue}, q);
      chk({31'h0, xferReqCompletion}, 32'h1);
    end
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #400000;
    errors++;
    final_report;
  end
  // ******************
  // Tests
  // ******************
  initial begin
    {psel, penable, pwrite, rst_n, writeStatusReq} = '0;
    {paddr, quickTriggerFlags, quickEnable, writeStatusFifoPending} = '0;
    {pwdata, eventIn, chanQueueSel, completionIrqEn} = '0;
    {manualEventSet, chainTriggerFlags, completionChainEn} = '0;
    stall = 1'b1;
    holdComp = 1'b1;
    k = $urandom(32'hbffc7748);
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    ch = 5'($urandom);
    chanQueueSel <= $urandom;
    completionIrqEn <= $urandom | (32'h1 << ch);
    completionChainEn <= $urandom;
    manualEventSet <= {31'h0, 1'($urandom)} << 5'($urandom);
    chainTriggerFlags <= {31'h0, 1'($urandom)} << 5'($urandom);
    quickTriggerFlags <= 8'($urandom);
    quickEnable <= 8'($urandom);
    writeStatusReq <= 1'($urandom);
    writeStatusFifoPending <= 1'($urandom);
    @(posedge clock);
    q = int'(chanQueueSel[ch]);
    sa = q ? `DQEL_OFS_QFILL1 : `DQEL_OFS_QFILL0;
    wb = writeStatusReq | writeStatusFifoPending;
    qb = |(quickTriggerFlags & quickEnable);
    eb = (|manualEventSet) | (|chainTriggerFlags);
    rdc(`DQEL_OFS_LIMIT, 32'h1010);
    rdc(sa, 32'h0);
    rdc(`DQEL_OFS_LATCH, 32'h0);
    rdc(8'hfc, 32'h0);
    done("reset");
    ev;
    rdc(`DQEL_OFS_LATCH, 32'h1 << ch);
    rdc(sa, 32'h0);
    apb(1'b1, `DQEL_OFS_EVCLEAR, 32'h1 << ch);
    rdc(`DQEL_OFS_LATCH, 32'h0);
    done("disabled event");
    apb(1'b1, `DQEL_OFS_LIMIT, 32'hffffe404);
    rdc(`DQEL_OFS_LIMIT, 32'h0404);
    apb(1'b1, `DQEL_OFS_ENABLE, 32'h1 << ch);
    repeat (18) ev;
    rdc(sa, st(1'b1, 5'h10, 5'h10, 4'h0));
    rdc(`DQEL_OFS_MISSED, 32'h1 << ch);
    rdc(`DQEL_OFS_LATCH, 32'h1 << ch);
    chk({30'h0, queueOverLimitError}, 32'h1 << q);
    apb(1'b1, `DQEL_OFS_ERRCLEAR, 32'h0);
    rdc(`DQEL_OFS_ERRFLAGS, 32'h1 << q);
    rdc(`DQEL_OFS_ACTIVITY, {14'h0, q == 1, q == 0, 11'h0, 1'b1, wb, 1'b1,
        qb, 1'b1});
    done("fill");
    stall <= 1'b0;
    waitPops(17);
    rdc(`DQEL_OFS_LATCH, 32'h0);
    rdc(sa, st(1'b1, 5'h10, 5'h0, 4'h1));
    apb(1'b0, `DQEL_OFS_ACTIVITY, 32'h0);
    chk(rd & 32'h3ff00, 32'h1100);
    apb(1'b1, `DQEL_OFS_ERRCLEAR, 32'h1 << q);
    rdc(sa, st(1'b0, 5'h0, 5'h0, 4'h1));
    rdc(`DQEL_OFS_ERRFLAGS, 32'h0);
    done("drain");
    repeat (46) ev;
    waitPops(63);
    ev;
    repeat (4) @(posedge clock);
    @(negedge clock);
    chk({31'h0, xferReqValid}, 32'h0);
    apb(1'b0, `DQEL_OFS_ACTIVITY, 32'h0);
    chk(rd & 32'h3ff00, (32'h1 << (16 + q)) | 32'h3f00);
    holdComp <= 1'b0;
    waitPops(64);
    for (k = 0; k < 400 && dqel_far_end_i.pend != 0; k++)
      @(posedge clock);
    repeat (4) @(posedge clock);
    apb(1'b0, `DQEL_OFS_ACTIVITY, 32'h0);
    chk(rd, {27'h0, wb | qb | eb, wb, 1'b0, qb, eb});
    {manualEventSet, chainTriggerFlags} <= '0;
    {writeStatusReq, writeStatusFifoPending} <= '0;
    quickEnable <= 8'h0;
    rdc(`DQEL_OFS_ACTIVITY, 32'h0);
    apb(1'b0, sa, 32'h0);
    chk(rd & 32'h1f0f, 32'h0);
    done("completion limit");
    rdc(`DQEL_OFS_SH_MISSED, 32'h0);
    apb(1'b1, `DQEL_OFS_GRANT, 32'h1 << ch);
    rdc(`DQEL_OFS_GRANT, 32'h1 << ch);
    rdc(`DQEL_OFS_SH_MISSED, 32'h1 << ch);
    apb(1'b1, `DQEL_OFS_SH_ENABLE, 32'hffffffff);
    rdc(`DQEL_OFS_ENABLE, 32'h1 << ch);
    apb(1'b1, `DQEL_OFS_SH_MISSED, 32'hffffffff);
    rdc(`DQEL_OFS_MISSED, 32'h0);
    done("shadow");
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rdc(`DQEL_OFS_LIMIT, 32'h1010);
    rdc(sa, 32'h0);
    rdc(`DQEL_OFS_ENABLE, 32'h0);
    rdc(`DQEL_OFS_GRANT, 32'h0);
    done("second reset");
    final_report;
  end
endmodule
